// ### hw/mcr_pkg.sv
package mcr_pkg;
    // Register offsets on the 8-bit register port.
    localparam logic [7:0] MCR_OFS_GAP_START = 8'h88;
    localparam logic [7:0] MCR_OFS_GAP_END = 8'h8c;
    localparam logic [7:0] MCR_OFS_WINDOW = 8'ha4;
    localparam logic [7:0] MCR_OFS_ERR_ADDR = 8'ha8;
    localparam logic [7:0] MCR_OFS_TIMING = 8'hac;

    // Reset values.
    localparam logic [31:0] MCR_RST_GAP_START = 32'h0000_0000;
    localparam logic [31:0] MCR_RST_GAP_END = 32'h0000_0000;
    localparam logic [31:0] MCR_RST_WINDOW = 32'h00fe_c001;
    localparam logic [31:0] MCR_RST_ERR_ADDR = 32'h0000_0000;
    localparam logic [31:0] MCR_RST_TIMING = 32'h30df_3516;

    // Field positions.
    localparam int MCR_GAP_EN_BIT = 31;
    localparam int MCR_GAP_ADDR_LSB = 0;
    localparam int MCR_WIN_EN_BIT = 0;
    localparam int MCR_WIN_BASE_LSB = 12;
    localparam int MCR_ERR_QW_LSB = 1;
    localparam int MCR_ERR_ADDR_LSB = 3;
    localparam int MCR_TIM_REFC_LSB = 20;
    localparam int MCR_TIM_REFS_LSB = 17;
    localparam int MCR_TIM_REFE_BIT = 16;
    localparam int MCR_TIM_LOW_LSB = 0;

    // Field widths.
    localparam int MCR_ADDR_HI_W = 16;
    localparam int MCR_REFC_W = 11;
    localparam int MCR_REFS_W = 3;
    localparam int MCR_TIM_LOW_W = 16;

    // Window span: 64 Kbytes, so host address bits 19:16 must be zero.
    localparam logic [3:0] MCR_WIN_SUB_MB = 4'h0;

    // Clock period of the system clock in ns.
    localparam int MCR_CLK_PERIOD_NS = 50;

    typedef enum logic [0:0] {
        MCR_STG_IDLE = 1'b0,
        MCR_STG_RUN = 1'b1
    } mcr_stg_state_t;
endpackage : mcr_pkg

// ### hw/mcr_refresh_timer.sv
module mcr_refresh_timer
    import mcr_pkg::*;
#(
    parameter int CNT_W = MCR_REFC_W
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic enable_in,
    input wire logic [CNT_W-1:0] interval_in,
    output logic refresh_pulse_out
);
    initial begin
        if (CNT_W < 1 || CNT_W > 16) begin
            $error("mcr_refresh_timer: CNT_W out of range");
        end
    end

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic run;
        logic pulse;
    } mcr_tmr_state_t;

    mcr_tmr_state_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.pulse = 1'b0;
        if (!enable_in || interval_in == '0) begin
            s_d.run = 1'b0;
        end else if (!s_q.run) begin
            s_d.run = 1'b1;
            s_d.cnt = interval_in;
        end else if (s_q.cnt == CNT_W'(1)) begin
            s_d.pulse = 1'b1;
            s_d.cnt = interval_in;
        end else begin
            s_d.cnt = s_q.cnt - CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign refresh_pulse_out = s_q.pulse;

    logic [CNT_W:0] since_q;
    logic armed_q;
    logic [CNT_W-1:0] last_int_q;
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            since_q <= '0;
            armed_q <= 1'b0;
            last_int_q <= '0;
        end else begin
            since_q <= s_q.pulse ? (CNT_W+1)'(1) : since_q + (CNT_W+1)'(1);
            last_int_q <= interval_in;
            if (!enable_in || interval_in != last_int_q) begin
                armed_q <= 1'b0;
            end else if (s_q.pulse) begin
                armed_q <= 1'b1;
            end
        end
    end

    property p_refresh_period;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (s_q.pulse && armed_q && $stable(interval_in)) |-> since_q == {1'b0, interval_in};
    endproperty
    a_refresh_period: assert property (p_refresh_period) else $error("refresh spacing wrong");

    property p_no_refresh_off;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (!enable_in) |=> !s_q.pulse;
    endproperty
    a_no_refresh_off: assert property (p_no_refresh_off) else $error("refresh while off");

    c_refresh: cover property (@(posedge core_clk_in) disable iff (!rstn_in) s_q.pulse && armed_q);
endmodule : mcr_refresh_timer

// ### hw/mcr_regs.sv
// Notes on behaviour
// - The high gap end register keeps address bits 35:20 of the last 1 MB block in bits 15:0.
// - The window base field in bits 27:12 gives address bits 35:20 on 1 MB boundaries.
// - With the window enable bit 0 set, the default, accesses in the 64 KB window are ignored.
// - Window register bits 11:1 are reserved here and read as zero.
// - The first uncorrectable error captures bits 31:3 of the effective internal address.
// - Bits 2:1 of the error address hold the failing quadword in transfer order.
// - An error in a single-quadword transfer records quadword position 00.
// - The captured error address means something only while the error flag is set.
// - Every DRAM control output is made on the system clock, in whole clock periods.
// - The timing register holds refresh interval, row stagger, refresh enable and timings.
// - Bits 30:20 count clocks between refreshes, 1 to 2047, one refresh per count that ends with the row stagger idle.
// - Bits 19:17 set the clocks between refresh of successive rows, 000 meaning all at once.
// - The gap start register holds address bits 35:20 in bits 15:0 and its enable in bit 31.
//
// Decided for this implementation: the plain strobed port.
module mcr_regs
    import mcr_pkg::*;
#(
    parameter int ROWS = 4
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic host_req_in,
    input wire logic [35:0] host_addr_in,
    output logic decode_valid_out,
    output logic mem_ignore_out,
    output logic in_high_gap_out,
    input wire logic qw_valid_in,
    input wire logic xfer_start_in,
    input wire logic xfer_single_in,
    input wire logic ecc_uncorr_in,
    input wire logic [31:0] ecc_eff_addr_in,
    input wire logic err_flag_clr_in,
    output logic uncorrectable_error_flag_out,
    output logic [ROWS-1:0] row_refresh_out,
    output logic refresh_busy_out,
    output logic [MCR_TIM_LOW_W-1:0] dram_timing_fields_out
);
    initial begin
        if (ROWS < 1 || ROWS > 16) begin
            $error("mcr_regs: ROWS out of range");
        end
    end

    typedef struct packed {
        logic gap_en;
        logic [MCR_ADDR_HI_W-1:0] gap_start;
        logic [MCR_ADDR_HI_W-1:0] gap_end;
        logic win_en;
        logic [MCR_ADDR_HI_W-1:0] win_base;
        logic err_flag;
        logic [28:0] err_addr;
        logic [1:0] err_qw;
        logic [1:0] qw_cnt;
        logic [MCR_REFC_W-1:0] refc;
        logic [MCR_REFS_W-1:0] refs;
        logic refe;
        logic [MCR_TIM_LOW_W-1:0] tim_low;
        logic [31:0] rdata;
        logic dec_valid;
        logic dec_ignore;
        logic dec_gap;
    } mcr_regs_t;

    localparam mcr_regs_t MCR_REGS_RESET = '{
        gap_en: MCR_RST_GAP_START[MCR_GAP_EN_BIT],
        gap_start: MCR_RST_GAP_START[MCR_GAP_ADDR_LSB +: MCR_ADDR_HI_W],
        gap_end: MCR_RST_GAP_END[MCR_GAP_ADDR_LSB +: MCR_ADDR_HI_W],
        win_en: MCR_RST_WINDOW[MCR_WIN_EN_BIT],
        win_base: MCR_RST_WINDOW[MCR_WIN_BASE_LSB +: MCR_ADDR_HI_W],
        err_flag: 1'b0,
        err_addr: MCR_RST_ERR_ADDR[31:MCR_ERR_ADDR_LSB],
        err_qw: MCR_RST_ERR_ADDR[MCR_ERR_QW_LSB +: 2],
        qw_cnt: 2'h0,
        refc: MCR_RST_TIMING[MCR_TIM_REFC_LSB +: MCR_REFC_W],
        refs: MCR_RST_TIMING[MCR_TIM_REFS_LSB +: MCR_REFS_W],
        refe: MCR_RST_TIMING[MCR_TIM_REFE_BIT],
        tim_low: MCR_RST_TIMING[MCR_TIM_LOW_LSB +: MCR_TIM_LOW_W],
        rdata: 32'h0000_0000,
        dec_valid: 1'b0,
        dec_ignore: 1'b0,
        dec_gap: 1'b0
    };

    mcr_regs_t s_q, s_d;

    logic [MCR_ADDR_HI_W-1:0] host_mb;
    logic win_hit;
    logic gap_hit;
    logic [1:0] qw_pos;
    logic refresh_pulse;

    always_comb begin
        host_mb = host_addr_in[35:20];
        win_hit = s_q.win_en && host_mb == s_q.win_base
            && host_addr_in[19:16] == MCR_WIN_SUB_MB;
        gap_hit = s_q.gap_en && host_mb >= s_q.gap_start
            && host_mb <= s_q.gap_end;
        if (xfer_single_in || xfer_start_in) begin
            qw_pos = 2'h0;
        end else begin
            qw_pos = s_q.qw_cnt;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.rdata = 32'h0000_0000;
        s_d.dec_valid = host_req_in;
        s_d.dec_ignore = host_req_in && win_hit;
        s_d.dec_gap = host_req_in && gap_hit;

        if (qw_valid_in) begin
            s_d.qw_cnt = qw_pos + 2'h1;
        end

        // A new error in the clearing cycle keeps the flag set and is captured.
        if (err_flag_clr_in) begin
            s_d.err_flag = 1'b0;
        end
        if (ecc_uncorr_in && qw_valid_in && (!s_q.err_flag || err_flag_clr_in)) begin
            s_d.err_flag = 1'b1;
            s_d.err_addr = ecc_eff_addr_in[31:MCR_ERR_ADDR_LSB];
            s_d.err_qw = qw_pos;
        end

        if (reg_wr_in) begin
            if (reg_addr_in == MCR_OFS_GAP_START) begin
                s_d.gap_en = reg_wdata_in[MCR_GAP_EN_BIT];
                s_d.gap_start = reg_wdata_in[MCR_GAP_ADDR_LSB +: MCR_ADDR_HI_W];
            end else if (reg_addr_in == MCR_OFS_GAP_END) begin
                s_d.gap_end = reg_wdata_in[MCR_GAP_ADDR_LSB +: MCR_ADDR_HI_W];
            end else if (reg_addr_in == MCR_OFS_WINDOW) begin
                s_d.win_en = reg_wdata_in[MCR_WIN_EN_BIT];
                s_d.win_base = reg_wdata_in[MCR_WIN_BASE_LSB +: MCR_ADDR_HI_W];
            end else if (reg_addr_in == MCR_OFS_TIMING) begin
                s_d.refc = reg_wdata_in[MCR_TIM_REFC_LSB +: MCR_REFC_W];
                s_d.refs = reg_wdata_in[MCR_TIM_REFS_LSB +: MCR_REFS_W];
                s_d.refe = reg_wdata_in[MCR_TIM_REFE_BIT];
                s_d.tim_low = reg_wdata_in[MCR_TIM_LOW_LSB +: MCR_TIM_LOW_W];
            end
        end

        if (reg_rd_in) begin
            if (reg_addr_in == MCR_OFS_GAP_START) begin
                s_d.rdata[MCR_GAP_EN_BIT] = s_q.gap_en;
                s_d.rdata[MCR_GAP_ADDR_LSB +: MCR_ADDR_HI_W] = s_q.gap_start;
            end else if (reg_addr_in == MCR_OFS_GAP_END) begin
                s_d.rdata[MCR_GAP_ADDR_LSB +: MCR_ADDR_HI_W] = s_q.gap_end;
            end else if (reg_addr_in == MCR_OFS_WINDOW) begin
                s_d.rdata[MCR_WIN_EN_BIT] = s_q.win_en;
                s_d.rdata[MCR_WIN_BASE_LSB +: MCR_ADDR_HI_W] = s_q.win_base;
            end else if (reg_addr_in == MCR_OFS_ERR_ADDR) begin
                s_d.rdata[31:MCR_ERR_ADDR_LSB] = s_q.err_addr;
                s_d.rdata[MCR_ERR_QW_LSB +: 2] = s_q.err_qw;
            end else if (reg_addr_in == MCR_OFS_TIMING) begin
                s_d.rdata[MCR_TIM_REFC_LSB +: MCR_REFC_W] = s_q.refc;
                s_d.rdata[MCR_TIM_REFS_LSB +: MCR_REFS_W] = s_q.refs;
                s_d.rdata[MCR_TIM_REFE_BIT] = s_q.refe;
                s_d.rdata[MCR_TIM_LOW_LSB +: MCR_TIM_LOW_W] = s_q.tim_low;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_q <= MCR_REGS_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    mcr_refresh_timer #(
        .CNT_W(MCR_REFC_W)
    ) u_timer (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .enable_in(s_q.refe),
        .interval_in(s_q.refc),
        .refresh_pulse_out(refresh_pulse)
    );

    mcr_row_stagger #(
        .ROWS(ROWS)
    ) u_stagger (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .start_in(refresh_pulse),
        .stagger_in(s_q.refs),
        .row_refresh_out(row_refresh_out),
        .busy_out(refresh_busy_out)
    );

    assign reg_rdata_out = s_q.rdata;
    assign decode_valid_out = s_q.dec_valid;
    assign mem_ignore_out = s_q.dec_ignore;
    assign in_high_gap_out = s_q.dec_gap;
    assign uncorrectable_error_flag_out = s_q.err_flag;
    assign dram_timing_fields_out = s_q.tim_low;

    property p_window_ignore;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (host_req_in && s_q.win_en && host_addr_in[35:16] == {s_q.win_base, 4'h0})
        |=> mem_ignore_out && decode_valid_out;
    endproperty
    a_window_ignore: assert property (p_window_ignore) else $error("window access not ignored");

    property p_window_off;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (host_req_in && !s_q.win_en) |=> !mem_ignore_out;
    endproperty
    a_window_off: assert property (p_window_off) else $error("disabled window ignored access");

    property p_gap_range;
        @(posedge core_clk_in) disable iff (!rstn_in)
        host_req_in |=> in_high_gap_out == ($past(s_q.gap_en)
            && $past(host_addr_in[35:20]) >= $past(s_q.gap_start)
            && $past(host_addr_in[35:20]) <= $past(s_q.gap_end));
    endproperty
    a_gap_range: assert property (p_gap_range) else $error("gap decode wrong");

    property p_err_hold;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (s_q.err_flag && !err_flag_clr_in) |=> $stable(s_q.err_addr) && $stable(s_q.err_qw);
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error capture overwritten");

    property p_err_capture;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (ecc_uncorr_in && qw_valid_in && !s_q.err_flag)
        |=> uncorrectable_error_flag_out && s_q.err_addr == $past(ecc_eff_addr_in[31:3]);
    endproperty
    a_err_capture: assert property (p_err_capture) else $error("error address not captured");

    property p_single_qw;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (ecc_uncorr_in && qw_valid_in && xfer_single_in && !s_q.err_flag) |=> s_q.err_qw == 2'h0;
    endproperty
    a_single_qw: assert property (p_single_qw) else $error("single quadword position not 00");

    property p_qw_order;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (qw_valid_in && xfer_start_in && !xfer_single_in) ##1 (qw_valid_in && !xfer_start_in
            && !xfer_single_in && ecc_uncorr_in && !s_q.err_flag) |=> s_q.err_qw == 2'h1;
    endproperty
    a_qw_order: assert property (p_qw_order) else $error("quadword order wrong");

    property p_window_rsv;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (reg_rd_in && reg_addr_in == MCR_OFS_WINDOW) |=> reg_rdata_out[11:1] == 11'h000
            && reg_rdata_out[31:28] == 4'h0;
    endproperty
    a_window_rsv: assert property (p_window_rsv) else $error("window reserved bits nonzero");

    property p_gap_end_rsv;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (reg_rd_in && reg_addr_in == MCR_OFS_GAP_END) |=> reg_rdata_out[31:16] == 16'h0000
            && reg_rdata_out[15:0] == $past(s_q.gap_end);
    endproperty
    a_gap_end_rsv: assert property (p_gap_end_rsv) else $error("gap end readback wrong");

    property p_dec_follow;
        @(posedge core_clk_in) disable iff (!rstn_in)
        host_req_in
        |=> decode_valid_out;
    endproperty
    a_dec_follow: assert property (p_dec_follow) else $error("request not decoded");

    property p_win_span;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (host_req_in && host_addr_in[19:16] != MCR_WIN_SUB_MB)
        |=> !mem_ignore_out;
    endproperty
    a_win_span: assert property (p_win_span) else $error("ignore outside 64 KB");

    property p_win_base;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (host_req_in && host_addr_in[35:20] != s_q.win_base)
        |=> !mem_ignore_out;
    endproperty
    a_win_base: assert property (p_win_base) else $error("ignore off base");

    property p_gap_above;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (host_req_in && host_addr_in[35:20] > s_q.gap_end)
        |=> !in_high_gap_out;
    endproperty
    a_gap_above: assert property (p_gap_above) else $error("gap hit above end");

    property p_win_write;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (reg_wr_in && reg_addr_in == MCR_OFS_WINDOW)
        |=> s_q.win_base == $past(reg_wdata_in[27:12]) && s_q.win_en == $past(reg_wdata_in[0]);
    endproperty
    a_win_write: assert property (p_win_write) else $error("window write lost");

    property p_err_quiet;
        @(posedge core_clk_in) disable iff (!rstn_in)
        !ecc_uncorr_in
        |=> $stable(s_q.err_addr) && $stable(s_q.err_qw);
    endproperty
    a_err_quiet: assert property (p_err_quiet) else $error("capture without error");

    property p_err_clear;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (err_flag_clr_in && !(ecc_uncorr_in && qw_valid_in))
        |=> !uncorrectable_error_flag_out;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error flag not cleared");

    property p_err_sticky;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (uncorrectable_error_flag_out && !err_flag_clr_in)
        |=> uncorrectable_error_flag_out;
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped");

    property p_tim_read;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (reg_rd_in && reg_addr_in == MCR_OFS_TIMING)
        |=> reg_rdata_out[15:0] == dram_timing_fields_out && !reg_rdata_out[31];
    endproperty
    a_tim_read: assert property (p_tim_read) else $error("timing readback wrong");

    property p_start_rsv;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (reg_rd_in && reg_addr_in == MCR_OFS_GAP_START)
        |=> reg_rdata_out[30:16] == 15'h0000;
    endproperty
    a_start_rsv: assert property (p_start_rsv) else $error("gap start reserved bits set");

    c_window_hit: cover property (@(posedge core_clk_in) disable iff (!rstn_in) mem_ignore_out);
    c_gap_hit: cover property (@(posedge core_clk_in) disable iff (!rstn_in) in_high_gap_out);
    c_err_cap: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
        $rose(uncorrectable_error_flag_out) && s_q.err_qw == 2'h3);
endmodule : mcr_regs

// ### hw/mcr_row_stagger.sv
module mcr_row_stagger
    import mcr_pkg::*;
#(
    parameter int ROWS = 4
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic start_in,
    input wire logic [MCR_REFS_W-1:0] stagger_in,
    output logic [ROWS-1:0] row_refresh_out,
    output logic busy_out
);
    localparam int IDX_W = (ROWS > 1) ? $clog2(ROWS) : 1;

    initial begin
        if (ROWS < 1 || ROWS > 16) begin
            $error("mcr_row_stagger: ROWS out of range");
        end
    end

    typedef struct packed {
        mcr_stg_state_t st;
        logic [IDX_W-1:0] idx;
        logic [MCR_REFS_W-1:0] gap;
        logic [MCR_REFS_W-1:0] step;
        logic [ROWS-1:0] rows;
    } mcr_stg_t;

    mcr_stg_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.rows = '0;
        case (s_q.st)
            MCR_STG_IDLE: begin
                if (start_in) begin
                    if (stagger_in == '0 || ROWS == 1) begin
                        s_d.rows = '1;
                    end else begin
                        s_d.rows[0] = 1'b1;
                        s_d.idx = IDX_W'(1);
                        s_d.step = stagger_in;
                        s_d.gap = stagger_in;
                        s_d.st = MCR_STG_RUN;
                    end
                end
            end
            MCR_STG_RUN: begin
                if (s_q.gap == MCR_REFS_W'(1)) begin
                    s_d.rows[s_q.idx] = 1'b1;
                    s_d.gap = s_q.step;
                    if (32'(s_q.idx) == ROWS - 1) begin
                        s_d.st = MCR_STG_IDLE;
                    end else begin
                        s_d.idx = s_q.idx + IDX_W'(1);
                    end
                end else begin
                    s_d.gap = s_q.gap - MCR_REFS_W'(1);
                end
            end
            default: begin
                s_d.st = MCR_STG_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign row_refresh_out = s_q.rows;
    assign busy_out = (s_q.st == MCR_STG_RUN);

    property p_all_at_once;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (start_in && s_q.st == MCR_STG_IDLE && stagger_in == '0) |=> row_refresh_out == '1;
    endproperty
    a_all_at_once: assert property (p_all_at_once) else $error("rows not refreshed together");

    property p_stagger_one;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (start_in && s_q.st == MCR_STG_IDLE && stagger_in == 3'h1 && ROWS > 1)
        |=> row_refresh_out[0] ##1 row_refresh_out[1];
    endproperty
    a_stagger_one: assert property (p_stagger_one) else $error("stagger of one clock wrong");

    c_staggered: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
        busy_out && row_refresh_out != '0);
endmodule : mcr_row_stagger

// ### testbench/mcr_host_model.sv
module mcr_host_model
    import mcr_pkg::*;
(
    input wire logic core_clk_in,
    output logic host_req_out,
    output logic [35:0] host_addr_out,
    output logic qw_valid_out,
    output logic xfer_start_out,
    output logic xfer_single_out,
    output logic ecc_uncorr_out,
    output logic [31:0] ecc_eff_addr_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        host_req_out = 1'b0;
        host_addr_out = 36'h0;
        qw_valid_out = 1'b0;
        xfer_start_out = 1'b0;
        xfer_single_out = 1'b0;
        ecc_uncorr_out = 1'b0;
        ecc_eff_addr_out = 32'h0;
    end

    // One host access; the address bus is scrambled once the request is gone.
    task automatic access(input logic [35:0] a);
        @(posedge core_clk_in);
        host_req_out <= 1'b1;
        host_addr_out <= a;
        @(posedge core_clk_in);
        host_req_out <= 1'b0;
        host_addr_out <= ~a;
        #1;
    endtask : access

    // Streams n quadwords in transfer order with an uncorrectable error on quadword errq.
    task automatic xfer(input int n, input int errq, input logic [31:0] a);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk_in);
            qw_valid_out <= 1'b1;
            xfer_start_out <= (i == 0 && n > 1);
            xfer_single_out <= (n == 1);
            ecc_uncorr_out <= (i == errq);
            ecc_eff_addr_out <= (i == errq) ? a : ~a;
        end
        @(posedge core_clk_in);
        qw_valid_out <= 1'b0;
        xfer_start_out <= 1'b0;
        xfer_single_out <= 1'b0;
        ecc_uncorr_out <= 1'b0;
        ecc_eff_addr_out <= ~a;
        #1;
    endtask : xfer
endmodule : mcr_host_model

// ### testbench/mem_ctrl_decode_error_timing_regs_tb.sv
module mem_ctrl_decode_error_timing_regs_tb
    import mcr_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic err_clr = 1'b0;
    logic [31:0] rdata, eff_addr;
    logic host_req, qw_valid, xfer_start, xfer_single, ecc_uncorr;
    logic [35:0] host_addr;
    logic dec_valid, ignore, in_gap, err_flag, busy;
    logic [3:0] rows;
    logic [15:0] tim_low;
    int err_total = 0;
    int total_checks = 0;
    int c;

    always #25 core_clk = ~core_clk;

    mcr_regs uut (.core_clk_in(core_clk), .rstn_in(rstn), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(rdata), .host_req_in(host_req), .host_addr_in(host_addr),
        .decode_valid_out(dec_valid), .mem_ignore_out(ignore), .in_high_gap_out(in_gap),
        .qw_valid_in(qw_valid), .xfer_start_in(xfer_start), .xfer_single_in(xfer_single),
        .ecc_uncorr_in(ecc_uncorr), .ecc_eff_addr_in(eff_addr), .err_flag_clr_in(err_clr),
        .uncorrectable_error_flag_out(err_flag), .row_refresh_out(rows),
        .refresh_busy_out(busy), .dram_timing_fields_out(tim_low));

    mcr_host_model host (.core_clk_in(core_clk), .host_req_out(host_req),
        .host_addr_out(host_addr), .qw_valid_out(qw_valid), .xfer_start_out(xfer_start),
        .xfer_single_out(xfer_single), .ecc_uncorr_out(ecc_uncorr),
        .ecc_eff_addr_out(eff_addr));

    task automatic results;
        if (err_total == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rd

    // Host access followed by a check of the three decode outputs.
    task automatic hit(input logic [35:0] a, input logic ig, input logic gp);
        host.access(a);
        chk({29'h0, dec_valid, ignore, in_gap}, {29'h0, 1'b1, ig, gp});
    endtask : hit

    // Returns the number of cycles until row 0 refreshes; a stall ends the run.
    task automatic wait_row0(input int bound, output int k);
        for (k = 1; k <= bound; k++) begin
            @(posedge core_clk);
            #1;
            if (rows[0] === 1'b1) begin
                return;
            end
        end
        err_total++;
        $display("ERROR %0t no row refresh", $time);
        results();
    endtask : wait_row0

    initial begin
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        rd(MCR_OFS_GAP_START, MCR_RST_GAP_START);
        rd(MCR_OFS_GAP_END, 32'h0000_0000);
        rd(MCR_OFS_WINDOW, 32'h00fe_c001);
        rd(MCR_OFS_ERR_ADDR, 32'h0000_0000);
        rd(MCR_OFS_TIMING, 32'h30df_3516);
        rd(8'h00, 32'h0000_0000);
        wr(MCR_OFS_GAP_END, 32'hffff_ffff);
        rd(MCR_OFS_GAP_END, 32'h0000_ffff);
        wr(MCR_OFS_WINDOW, 32'h0fff_fff1);
        rd(MCR_OFS_WINDOW, 32'h0fff_f001);
        wr(MCR_OFS_ERR_ADDR, 32'hffff_ffff);
        rd(MCR_OFS_ERR_ADDR, 32'h0000_0000);
        wr(MCR_OFS_GAP_START, 32'h8000_0100);
        wr(MCR_OFS_GAP_END, 32'h0000_0102);
        rd(MCR_OFS_GAP_START, 32'h8000_0100);
        hit(36'h100_00000, 1'b0, 1'b1);
        hit(36'h102_fffff, 1'b0, 1'b1);
        hit(36'h103_00000, 1'b0, 1'b0);
        hit(36'h0ff_fffff, 1'b0, 1'b0);
        wr(MCR_OFS_WINDOW, 32'h00fe_c001);
        hit(36'h0fec_0ff00, 1'b1, 1'b0);
        hit(36'h0fec_10000, 1'b0, 1'b0);
        hit(36'h0fed_00000, 1'b0, 1'b0);
        wr(MCR_OFS_WINDOW, 32'h00fe_c000);
        hit(36'h0fec_0ff00, 1'b0, 1'b0);
        host.xfer(4, 2, 32'h1234_5678);
        chk({31'h0, err_flag}, 32'h1);
        rd(MCR_OFS_ERR_ADDR, {29'h0246_8acf, 2'b10, 1'b0});
        host.xfer(4, 0, 32'hdead_beef);
        rd(MCR_OFS_ERR_ADDR, {29'h0246_8acf, 2'b10, 1'b0});
        @(posedge core_clk);
        err_clr <= 1'b1;
        @(posedge core_clk);
        err_clr <= 1'b0;
        #1;
        chk({31'h0, err_flag}, 32'h0);
        host.xfer(2, 1, 32'h0000_1008);
        rd(MCR_OFS_ERR_ADDR, 32'h0000_100a);
        @(posedge core_clk);
        err_clr <= 1'b1;
        @(posedge core_clk);
        err_clr <= 1'b0;
        host.xfer(1, 0, 32'h0000_0ff8);
        rd(MCR_OFS_ERR_ADDR, 32'h0000_0ff8);
        wr(MCR_OFS_TIMING, 32'h0083_1234);
        #1;
        chk({16'h0, tim_low}, 32'h0000_1234);
        wait_row0(2000, c);
        wait_row0(20, c);
        chk({28'h0, rows}, 32'h1);
        @(posedge core_clk);
        #1;
        chk({28'h0, rows}, 32'h2);
        chk({31'h0, busy}, 32'h1);
        wait_row0(20, c);
        chk(c, 7);
        wr(MCR_OFS_TIMING, 32'h0081_0000);
        wait_row0(20, c);
        wait_row0(20, c);
        chk({28'h0, rows}, 32'hf);
        wr(MCR_OFS_TIMING, 32'h0080_0000);
        repeat (10) @(posedge core_clk);
        c = 0;
        repeat (20) begin
            @(posedge core_clk);
            #1;
            c = c | int'(rows);
        end
        chk(c, 0);
        chk({31'h0, busy}, 32'h0);
        results();
    end
endmodule : mem_ctrl_decode_error_timing_regs_tb
